//--- rtl/ssp_core.sv
// Synchronous serial port: AXI4-Lite registers, FIFOs, master/slave shifter.
// Assumes a peripheral on the link pins; slave pins arrive asynchronously.
`default_nettype none
// Behaviour
// - Busy while shifting or transmit FIFO holds words; idle only when all drained.
// - Six frame formats: four clock modes, frame pulse, half-duplex command.
// - Mode 0..3 map to polarity/phase 00, 01, 10, 11.
// - Master or slave; slave may stop driving its serial output.
// - Frame width programmable 4 to 16 bits, frames carry exactly that.
// - Received word read shows only its low N bits.
// - Transmit word upper 32-N bits ignored, low N bits sent.
// - Written words queue in transmit FIFO and go out in order.
// - Receive FIFO not empty indication visible to software.
// - Transmit FIFO not full indication visible to software.
// - Global enable; cleared stops all serial operation.
// - Bit clock derived from the processor clock itself.
// - Independent eight-entry 16-bit FIFOs for transmit and receive.
// - Four raw interrupt sources, masked onto the processor interrupt.
module ssp_core (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe,
	input  wire logic        sfrm_in,
	output logic             sfrm_out,
	output logic             sfrm_oe,
	output logic             mosi_out,
	output logic             mosi_oe,
	input  wire logic        miso_in,
	output logic             irq
);
	localparam int DW = ssp_pkg::DATA_MAX;

	// Registers
	ssp_pkg::ssp_ctrl_s ctrl_q;
	logic [15:0]        cdiv_q;
	ssp_pkg::ssp_irq_s  iraw_q, ien_q;

	// AXI write path: address and data latched independently
	logic       aw_have_q, w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	wire        wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	wire        wr_map  = awaddr_q inside {ssp_pkg::OFS_CTRL, ssp_pkg::OFS_DATA,
		ssp_pkg::OFS_CDIV, ssp_pkg::OFS_IEN, ssp_pkg::OFS_ICLR};
	wire        wr_ctrl = wr_fire && awaddr_q == ssp_pkg::OFS_CTRL;
	wire        wr_data = wr_fire && awaddr_q == ssp_pkg::OFS_DATA;
	wire        wr_cdiv = wr_fire && awaddr_q == ssp_pkg::OFS_CDIV;
	wire        wr_ien  = wr_fire && awaddr_q == ssp_pkg::OFS_IEN;
	wire        wr_iclr = wr_fire && awaddr_q == ssp_pkg::OFS_ICLR;

	// Width mask; a width outside 4..16 clamps to the nearest legal value
	function automatic logic [4:0] eff_width(input logic [4:0] w);
		eff_width = (w < ssp_pkg::WIDTH_MIN) ? ssp_pkg::WIDTH_MIN :
			(w > ssp_pkg::WIDTH_MAX) ? ssp_pkg::WIDTH_MAX : w;
	endfunction : eff_width
	function automatic logic [DW-1:0] width_mask(input logic [4:0] w);
		width_mask = DW'((32'h1 << w) - 32'h1);
	endfunction : width_mask

	wire [4:0]    nbits = eff_width(ctrl_q.width);
	wire [DW-1:0] dmask = width_mask(nbits);

	// FIFOs
	logic [DW-1:0] tx_rd, rx_rd, rx_word;
	logic          tx_empty, tx_full, rx_empty, rx_full, tx_pop, rx_push;
	logic [3:0]    tx_lvl, rx_lvl;
	wire           rd_data;
	ssp_fifo #(.W(DW), .D(ssp_pkg::FIFO_DEPTH)) u_txf (
		.clock(clock), .sys_rst(sys_rst), .clr(!ctrl_q.enable),
		.push(wr_data), .wdata(wdata_q[DW-1:0] & dmask),
		.pop(tx_pop), .rdata(tx_rd), .empty(tx_empty), .full(tx_full), .level(tx_lvl));
	ssp_fifo #(.W(DW), .D(ssp_pkg::FIFO_DEPTH)) u_rxf (
		.clock(clock), .sys_rst(sys_rst), .clr(!ctrl_q.enable),
		.push(rx_push), .wdata(rx_word), .pop(rd_data),
		.rdata(rx_rd), .empty(rx_empty), .full(rx_full), .level(rx_lvl));

	// Slave pins pass a synchroniser before use
	logic [2:0] pin_s;
	ssp_sync #(.W(3)) u_sync (.clock(clock), .sys_rst(sys_rst),
		.din({sclk_in, sfrm_in, miso_in}), .dout(pin_s));
	wire s_sclk = pin_s[2];
	wire s_frm  = pin_s[1];
	wire s_din  = pin_s[0];

	// Format decode
	wire fmt_spi = ctrl_q.format <= 3'(ssp_pkg::spi_mode_pol1_ph1);
	wire fmt_fp  = ctrl_q.format == 3'(ssp_pkg::frame_pulse_format);
	wire fmt_hd  = ctrl_q.format == 3'(ssp_pkg::half_duplex_cmd_format);
	wire cpol    = fmt_spi && ctrl_q.format[1];
	wire cpha    = fmt_spi && ctrl_q.format[0];
	wire master  = ctrl_q.link_master_select;

	// Bit-rate divider: half-period = prescale*(divider+1), clock is the bus clock
	logic [15:0] div_cnt_q;
	wire  [15:0] half_per = {8'h00, cdiv_q[7:0]} * ({8'h00, cdiv_q[15:8]} + 16'h0001);
	wire         tick = div_cnt_q >= half_per - 16'h0001;

	// Shifter state
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_DONE = 2'b11} ssp_st_e;
	ssp_st_e     st_q;
	logic [DW-1:0] txsh_q, rxsh_q;
	logic [4:0]  bit_q;
	logic        phase_q, sclk_q, frm_q, sclk_prev_q;
	logic [7:0]  idle_q;

	// Slave edge detect on synchronised clock
	wire s_rise = s_sclk && !sclk_prev_q;
	wire s_fall = !s_sclk && sclk_prev_q;
	wire s_lead = cpol ? s_fall : s_rise;
	wire s_trail = cpol ? s_rise : s_fall;
	// Sample on leading edge when phase 0, trailing when phase 1
	wire s_samp  = cpha ? s_trail : s_lead;
	wire s_shift = cpha ? s_lead : s_trail;
	wire m_samp  = tick && phase_q == cpha;
	wire m_shift = tick && phase_q != cpha;
	wire samp    = master ? m_samp : s_samp && !s_frm;
	wire shft    = master ? m_shift : s_shift && !s_frm;
	wire last    = bit_q == nbits - 5'h01;

	assign tx_pop  = ctrl_q.enable && st_q == ST_IDLE && !tx_empty &&
		(master || !s_frm);
	assign rx_push = ctrl_q.enable && st_q == ST_SHIFT && samp && last;
	// Master reads its input through the same two flops: a loopback needs half_per of 4 or more
	assign rx_word = {rxsh_q[DW-2:0], s_din} & dmask;

	always_ff @(posedge clock) begin
		if (sys_rst)
			sclk_prev_q <= 1'b0;
		else
			sclk_prev_q <= s_sclk;
	end

	always_ff @(posedge clock) begin
		if (sys_rst || !ctrl_q.enable) begin
			st_q      <= ST_IDLE;
			div_cnt_q <= '0;
			phase_q   <= 1'b0;
			bit_q     <= '0;
			txsh_q    <= '0;
			rxsh_q    <= '0;
			frm_q     <= 1'b0;
		end else begin
			// Free-running so DONE and the receive timeout see ticks; a pop aligns it
			div_cnt_q <= (tick || tx_pop) ? '0 : div_cnt_q + 16'h0001;
			unique case (st_q)
				ST_IDLE: begin
					frm_q <= 1'b0;
					if (tx_pop) begin
						txsh_q  <= tx_rd << (5'(DW) - nbits);
						bit_q   <= '0;
						phase_q <= 1'b0;
						frm_q   <= fmt_fp;
						st_q    <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (tick)
						phase_q <= !phase_q;
					if (master && tick)
						frm_q <= 1'b0;
					if (samp)
						rxsh_q <= {rxsh_q[DW-2:0], s_din};
					// Phase 1 shows the first bit before its leading edge, so that edge keeps it
					if (shft && !(bit_q == '0 && cpha))
						txsh_q <= {txsh_q[DW-2:0], 1'b0};
					if (samp) begin
						bit_q <= bit_q + 5'h01;
						if (last)
							st_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (!master || tick)
						st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Master pin drive; slave may release its output
	wire drive_out = ctrl_q.enable && (master || !ctrl_q.slave_output_off_select);
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sclk_out <= 1'b0;
			sclk_oe  <= 1'b0;
			sfrm_out <= 1'b1;
			sfrm_oe  <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe  <= 1'b0;
		end else begin
			// Held through DONE so the last bit's edge reaches the pin
			sclk_out <= (st_q != ST_IDLE) ? (phase_q ^ cpol) : cpol;
			sclk_oe  <= ctrl_q.enable && master;
			sfrm_out <= fmt_fp ? frm_q : !(st_q != ST_IDLE);
			sfrm_oe  <= ctrl_q.enable && master;
			mosi_out <= txsh_q[DW-1];
			mosi_oe  <= drive_out && !(fmt_hd && st_q == ST_IDLE);
		end
	end

	// Receive timeout: FIFO holds words but the link stays quiet
	always_ff @(posedge clock) begin
		if (sys_rst || rx_empty || st_q != ST_IDLE)
			idle_q <= '0;
		else if (tick && idle_q != ssp_pkg::RXTO_BITS)
			idle_q <= idle_q + 8'h01;
	end

	// Interrupt events; a set in the clear cycle wins
	ssp_pkg::ssp_irq_s ev, clr_v;
	assign ev.tx_fifo_service_irq = ctrl_q.enable && tx_lvl <= ssp_pkg::FIFO_HALF;
	assign ev.rx_fifo_service_irq = rx_lvl >= ssp_pkg::FIFO_HALF;
	assign ev.rx_timeout_irq      = idle_q == ssp_pkg::RXTO_BITS - 8'h01 && tick;
	assign ev.rx_overrun_irq      = rx_push && rx_full;
	assign clr_v = wr_iclr ? ssp_pkg::ssp_irq_s'(wdata_q[3:0]) : '0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			iraw_q <= '0;
			ien_q  <= '0;
			irq    <= 1'b0;
		end else begin
			iraw_q <= (iraw_q & ~clr_v) | ev;
			if (wr_ien)
				ien_q <= ssp_pkg::ssp_irq_s'(wdata_q[3:0]);
			irq <= |(iraw_q & ien_q);
		end
	end

	// Control and divider registers
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_q <= '0;
			cdiv_q <= 16'h0101;
		end else begin
			if (wr_ctrl)
				ctrl_q <= ssp_pkg::ssp_ctrl_s'({21'h0, wdata_q[10:0]});
			if (wr_cdiv && wdata_q[7:0] != 8'h00)
				cdiv_q <= wdata_q[15:0];
		end
	end

	// AXI write channel handshakes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ssp_pkg::RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? ssp_pkg::RESP_OK : ssp_pkg::RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

	// Read decode
	wire busy = !tx_empty || st_q != ST_IDLE;
	wire [31:0] stat_w = {27'h0, busy, rx_full, !rx_empty, !tx_full, tx_empty};
	wire [7:0]  ra = s_axi_araddr;
	wire        ra_map = ra inside {ssp_pkg::OFS_CTRL, ssp_pkg::OFS_DATA, ssp_pkg::OFS_STAT,
		ssp_pkg::OFS_CDIV, ssp_pkg::OFS_IRAW, ssp_pkg::OFS_IEN, ssp_pkg::OFS_ICLR};
	wire [31:0] rsel =
		(ra == ssp_pkg::OFS_CTRL) ? 32'(ctrl_q) :
		(ra == ssp_pkg::OFS_DATA) ? {16'h0, rx_rd & dmask} :
		(ra == ssp_pkg::OFS_STAT) ? stat_w :
		(ra == ssp_pkg::OFS_CDIV) ? {16'h0, cdiv_q} :
		(ra == ssp_pkg::OFS_IRAW) ? {28'h0, iraw_q} :
		(ra == ssp_pkg::OFS_IEN)  ? {28'h0, ien_q} : 32'h0;
	assign rd_data = s_axi_arvalid && s_axi_arready && ra == ssp_pkg::OFS_DATA && !rx_empty;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= ssp_pkg::RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rsel;
			s_axi_rresp  <= ra_map ? ssp_pkg::RESP_OK : ssp_pkg::RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Assertions
	idle_means_empty_a: assert property (@(posedge clock) disable iff (sys_rst)
		!busy |-> tx_empty && st_q == ST_IDLE) else $error("busy low with work left");
	disable_stops_a: assert property (@(posedge clock) disable iff (sys_rst)
		!ctrl_q.enable |=> st_q == ST_IDLE) else $error("shifter ran while disabled");
	rx_masked_a: assert property (@(posedge clock) disable iff (sys_rst)
		rx_push |-> (rx_word & ~dmask) == '0) else $error("rx word wider than width");
	irq_masked_a: assert property (@(posedge clock) disable iff (sys_rst)
		$past(iraw_q & ien_q) == '0 && !$past(sys_rst) |-> !irq) else $error("irq unmasked");
	slave_off_a: assert property (@(posedge clock) disable iff (sys_rst)
		!master && ctrl_q.slave_output_off_select |=> !mosi_oe) else $error("slave drove out");
	width_range_a: assert property (@(posedge clock) disable iff (sys_rst)
		nbits >= ssp_pkg::WIDTH_MIN && nbits <= ssp_pkg::WIDTH_MAX) else $error("bad width");
	mode_map_a: assert property (@(posedge clock) disable iff (sys_rst)
		fmt_spi |-> {cpol, cpha} == ctrl_q.format[1:0]) else $error("mode map wrong");
	flag_set_a: assert property (@(posedge clock) disable iff (sys_rst)
		ev.rx_overrun_irq |=> iraw_q.rx_overrun_irq) else $error("overrun lost");
endmodule : ssp_core
`default_nettype wire

//--- include/ssp_pkg.sv
// Package for the synchronous serial port: register map, fields, formats, types.
// Assumes a 32-bit AXI4-Lite register bus and a 200 MHz system clock.
`default_nettype none
package ssp_pkg;
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_DATA     = 8'h04;
	localparam logic [7:0]  OFS_STAT     = 8'h08;
	localparam logic [7:0]  OFS_CDIV     = 8'h0C;
	localparam logic [7:0]  OFS_IRAW     = 8'h10;
	localparam logic [7:0]  OFS_IEN      = 8'h14;
	localparam logic [7:0]  OFS_ICLR     = 8'h18;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam int          DATA_MAX     = 16;
	localparam int          FIFO_DEPTH   = 8;
	localparam logic [4:0]  WIDTH_MIN    = 5'h04;
	localparam logic [4:0]  WIDTH_MAX    = 5'h10;
	localparam logic [7:0]  RXTO_BITS    = 8'h20;
	localparam logic [3:0]  FIFO_HALF    = 4'h4;
	localparam logic [2:0]  SYNC_SLAVE   = 3'h3;

	typedef enum logic [2:0] {
		spi_mode_pol0_ph0      = 3'h0,
		spi_mode_pol0_ph1      = 3'h1,
		spi_mode_pol1_ph0      = 3'h2,
		spi_mode_pol1_ph1      = 3'h3,
		frame_pulse_format     = 3'h4,
		half_duplex_cmd_format = 3'h5
	} ssp_format_e;

	// Control register layout, high bits first
	typedef struct packed {
		logic [20:0] rsvd;
		logic [4:0]  width;
		logic        slave_output_off_select;
		logic        link_master_select;
		logic [2:0]  format;
		logic        enable;
	} ssp_ctrl_s;

	typedef struct packed {
		logic rx_overrun_irq;
		logic rx_timeout_irq;
		logic rx_fifo_service_irq;
		logic tx_fifo_service_irq;
	} ssp_irq_s;

	typedef struct packed {
		logic sclk;
		logic sfrm;
		logic mosi;
		logic miso;
	} ssp_pins_s;
endpackage : ssp_pkg
`default_nettype wire

//--- rtl/ssp_fifo.sv
// Eight-deep flip-flop FIFO for transmit and receive words.
// Push when full and pop when empty are ignored; clear empties it.
`default_nettype none
module ssp_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         clr,
	input  wire logic         push,
	input  wire logic [W-1:0] wdata,
	input  wire logic         pop,
	output logic [W-1:0]      rdata,
	output logic              empty,
	output logic              full,
	output logic [$clog2(D):0] level
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	wire           do_push = push && !full;
	wire           do_pop  = pop && !empty;

	assign rdata = mem_q[rp_q];
	assign empty = (cnt_q == '0);
	assign full  = (cnt_q == (AW+1)'(D));
	assign level = cnt_q;

	always_ff @(posedge clock) begin
		if (do_push)
			mem_q[wp_q] <= wdata;
	end

	always_ff @(posedge clock) begin
		if (sys_rst || clr) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push)
				wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			if (do_pop)
				rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule : ssp_fifo
`default_nettype wire

//--- rtl/ssp_sync.sv
// Two-flop synchroniser for the serial link pins.
// Assumes inputs are asynchronous to clock.
`default_nettype none
module ssp_sync #(
	parameter int W = 3
) (
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] din,
	output logic [W-1:0]      dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule : ssp_sync
`default_nettype wire

//--- verif/ssp_peer.sv
// Far-side serial peripheral: loops data back as slave, drives frames as master.
// Assumes the bench sets pol/ph to the port's clock mode and calls drive_frame.
`default_nettype none
module ssp_peer (
	input  wire logic clock,
	input  wire logic sclk,
	input  wire logic sfrm,
	input  wire logic mosi_out,
	input  wire logic mosi_oe,
	input  wire logic pol,
	input  wire logic ph,
	output logic      p_sclk,
	output logic      p_sfrm,
	output logic      miso
);
	timeunit 1ns;
	timeprecision 1ps;
	// 72 ns bit time, kept above 12 system clocks while the port is slave
	localparam int HALF = 36;
	logic        drv;
	logic        p_bit;
	logic        hold_q;
	logic        mosi_q;
	logic [15:0] sh;
	int          n;
	logic [15:0] got[$];
	int          gotn[$];
	// Released lines toggle every cycle so a stale value never looks valid
	wire         mosi_w = mosi_oe ? mosi_out : ~mosi_q;
	assign miso = drv ? p_bit : (!sfrm ? mosi_w : ~hold_q);
	initial begin
		drv = 1'b0;
		p_bit = 1'b0;
		p_sclk = 1'b0;
		p_sfrm = 1'b1;
		sh = 16'h0000;
		n = 0;
		mosi_q = 1'b0;
		hold_q = 1'b0;
	end
	always @(posedge clock) begin
		mosi_q <= mosi_w;
		hold_q <= miso;
	end
	// Sample on the rising edge when polarity equals phase, else falling
	always @(sclk) if (!sfrm && sclk === (pol ~^ ph)) begin
		sh = {sh[14:0], mosi_w};
		n++;
	end
	always @(negedge sfrm) begin
		sh = 16'h0000;
		n = 0;
	end
	always @(posedge sfrm) begin
		got.push_back(sh);
		gotn.push_back(n);
	end
	// Master role for slave tests, most significant bit first
	task automatic drive_frame(input logic [15:0] d, input int bits);
		p_sclk = pol;
		drv = 1'b1;
		p_sfrm = 1'b0;
		#HALF;
		for (int i = bits - 1; i >= 0; i--) begin
			if (!ph) p_bit = d[i];
			#HALF p_sclk = ~p_sclk;
			if (ph) p_bit = d[i];
			#HALF p_sclk = ~p_sclk;
		end
		#HALF p_sfrm = 1'b1;
		drv = 1'b0;
	endtask : drive_frame
endmodule : ssp_peer
`default_nettype wire

//--- verif/tb.sv
// Testbench for the serial port: AXI4-Lite tasks and loopback peer.
// Assumes ssp_pkg, ssp_core and ssp_peer are compiled first.
`default_nettype none
`define CHK(g, e) begin v = 32'(g); checks++; if (v !== 32'(e)) begin err_count++; \
	$display("wrong value at %0t: got %h exp %h", $time, v, 32'(e)); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, sys_rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, oe_seen;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, v, ex;
	logic [1:0]  bresp, rresp, rs;
	logic        sclk_out, sclk_oe, sfrm_out, sfrm_oe, mosi_out, mosi_oe;
	logic        pol, ph, p_sclk, p_sfrm, miso;
	int          err_count, checks, cyc, w;
	int          wl[4] = '{4, 16, 8, 12};
	wire         sclk_w = sclk_oe ? sclk_out : p_sclk;
	wire         sfrm_w = sfrm_oe ? sfrm_out : p_sfrm;
	ssp_core ssp_core_inst (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.sfrm_in(sfrm_w), .sfrm_out(sfrm_out), .sfrm_oe(sfrm_oe), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso), .irq(irq));
	ssp_peer ssp_peer_inst (.clock(clock), .sclk(sclk_w), .sfrm(sfrm_w), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .pol(pol), .ph(ph), .p_sclk(p_sclk), .p_sfrm(p_sfrm), .miso(miso));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Response ready is held high throughout, so only valid needs releasing
	// Waits are unbounded here; only the cycle ceiling below ends a hung transfer
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
	endtask : wr
	task rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
	endtask : rdr
	task idle;
		int k;
		k = 0;
		do begin
			rdr(ssp_pkg::OFS_STAT);
			k++;
		end while (rd[4] !== 1'b0 && k < 2000);
	endtask : idle
	function automatic logic [31:0] cw(input int wd, input int f, input logic m, input logic o);
		return 32'(wd) << 6 | 32'(o) << 5 | 32'(m) << 4 | 32'(f) << 1 | 32'h1;
	endfunction : cw
	task stop_test;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (mosi_oe === 1'b1) oe_seen <= 1'b1;
		if (cyc == 60000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		{awaddr, araddr, wdata, awvalid, wvalid, arvalid, pol, ph, oe_seen} = '0;
		{sys_rst, bready, rready} = 3'h7;
		err_count = 0;
		checks = 0;
		cyc = 0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		rdr(ssp_pkg::OFS_CTRL); `CHK(rd, 32'h0)
		rdr(ssp_pkg::OFS_CDIV); `CHK(rd, 32'h0101)
		rdr(ssp_pkg::OFS_STAT); `CHK(rd, 32'h3)
		rdr(8'h1C); `CHK(rs, ssp_pkg::RESP_SLVERR)
		`CHK(rd, 32'h0)
		wr(ssp_pkg::OFS_STAT, 32'h0); `CHK(rs, ssp_pkg::RESP_SLVERR)
		wr(ssp_pkg::OFS_CDIV, 32'h4); `CHK(rs, ssp_pkg::RESP_OK)
		for (int m = 0; m < 4; m++) begin
			pol <= m[1];
			ph <= m[0];
			w = wl[m];
			ex = (32'hFFFF_A5C3 ^ m) & ((32'h1 << w) - 1);
			wr(ssp_pkg::OFS_CTRL, cw(w, m, 1'b1, 1'b0));
			ssp_peer_inst.got.delete();
			ssp_peer_inst.gotn.delete();
			wr(ssp_pkg::OFS_DATA, 32'hFFFF_A5C3 ^ m);
			rdr(ssp_pkg::OFS_STAT); `CHK(rd[4], 1'b1)
			idle();
			`CHK(ssp_peer_inst.got.pop_front(), ex)
			`CHK(ssp_peer_inst.gotn.pop_front(), w)
			rdr(ssp_pkg::OFS_DATA); `CHK(rd, ex)
			`CHK(sclk_w, pol)
		end
		pol <= 1'b0;
		ph <= 1'b0;
		wr(ssp_pkg::OFS_CTRL, cw(8, 0, 1'b1, 1'b0));
		ssp_peer_inst.got.delete();
		for (int i = 0; i < 9; i++) wr(ssp_pkg::OFS_DATA, 32'h100 + i * 17);
		idle();
		for (int i = 0; i < 9; i++) `CHK(ssp_peer_inst.got.pop_front(), i * 17)
		rdr(ssp_pkg::OFS_STAT); `CHK(rd, 32'hF)
		repeat (600) @(posedge clock);
		rdr(ssp_pkg::OFS_IRAW); `CHK(rd[3:2], 2'b11)
		for (int i = 0; i < 8; i++) begin
			rdr(ssp_pkg::OFS_DATA); `CHK(rd, i * 17)
		end
		rdr(ssp_pkg::OFS_STAT); `CHK(rd[2], 1'b0)
		wr(ssp_pkg::OFS_IEN, 32'h8);
		repeat (2) @(posedge clock); `CHK(irq, 1'b1)
		wr(ssp_pkg::OFS_IEN, 32'h0);
		repeat (2) @(posedge clock); `CHK(irq, 1'b0)
		wr(ssp_pkg::OFS_IEN, 32'hC);
		wr(ssp_pkg::OFS_ICLR, 32'hC);
		repeat (2) @(posedge clock); `CHK(irq, 1'b0)
		rdr(ssp_pkg::OFS_IRAW); `CHK(rd[3:2], 2'b00)
		// Slowest divider keeps the shifter busy while the FIFO fills
		wr(ssp_pkg::OFS_CDIV, 32'hFFFF);
		for (int i = 0; i < 10; i++) wr(ssp_pkg::OFS_DATA, i);
		rdr(ssp_pkg::OFS_STAT); `CHK(rd, 32'h10)
		wr(ssp_pkg::OFS_CTRL, 32'h0);
		repeat (4) @(posedge clock);
		rdr(ssp_pkg::OFS_STAT); `CHK(rd, 32'h3)
		`CHK(sfrm_w, 1'b1)
		wr(ssp_pkg::OFS_CDIV, 32'h4);
		for (int f = 4; f < 6; f++) begin
			wr(ssp_pkg::OFS_CTRL, cw(8, f, 1'b1, 1'b0));
			wr(ssp_pkg::OFS_DATA, 32'h3C);
			rdr(ssp_pkg::OFS_STAT); `CHK(rd[4], 1'b1)
			idle(); `CHK(rd[0], 1'b1)
			wr(ssp_pkg::OFS_CTRL, 32'h0);
		end
		ph <= 1'b1;
		wr(ssp_pkg::OFS_CTRL, cw(8, 1, 1'b0, 1'b0));
		wr(ssp_pkg::OFS_DATA, 32'h1C3);
		ssp_peer_inst.got.delete();
		ssp_peer_inst.drive_frame(16'h005A, 8);
		repeat (20) @(posedge clock);
		rdr(ssp_pkg::OFS_DATA); `CHK(rd, 32'h5A)
		`CHK(ssp_peer_inst.got.pop_front(), 32'hC3)
		wr(ssp_pkg::OFS_CTRL, cw(8, 1, 1'b0, 1'b1));
		wr(ssp_pkg::OFS_DATA, 32'h77);
		repeat (2) @(posedge clock);
		oe_seen <= 1'b0;
		ssp_peer_inst.drive_frame(16'h00A6, 8);
		repeat (20) @(posedge clock);
		rdr(ssp_pkg::OFS_DATA); `CHK(rd, 32'hA6)
		`CHK(oe_seen, 1'b0)
		stop_test();
	end
endmodule : tb
`undef CHK
`default_nettype wire
